//--- design/pmft_pkg.sv
/*
  Constants shared by the fault-status and telemetry register set:
  command codes, field positions, reset values and link framing figures.
  Assumes a PMBus host on the far end of an open-drain two-wire link.
*/
// Overview of operation
// R1: command 80h returns one vendor fault byte, reset value 00h.
// R2: bit 7 latches when the power stage reports a fault.
// R3: bit 6 latches on a pre-bias fault, output above 2.75 V at startup.
// R4: bits 5:3, current-share warning, always read zero.
// R5: bit 2 latches on an output reset-voltage fault.
// R6: bit 1 latches on a minimum output voltage fault.
// R7: bit 0 latches when no phase switching pulse is detected.
// R8: command 88h returns input voltage as a linear word.
// R9: linear word: 5-bit signed exponent 15:11, 11-bit signed mantissa 10:0.
// R10: command 89h returns input current as a linear word.
// R11: command 8Bh returns measured output voltage as a 16-bit VID word.
// R12: command D4h returns the same output voltage in linear format.
// R13: command 8Ch returns output current as a linear word.
// R14: command 8Dh returns temperature as a linear word.
// R15: status and telemetry fields are read-only; besides clear-faults, host writes change only comm status bit 4, and only during memory programming.
// R16: comm status bit 4 latches on a write while memory programming runs.
// R17: latched flags hold until the clear-faults command or reset.
// R18: 16-bit words go out low byte first.

package pmft_pkg;

  // ===========================================================
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_FAULT_STATUS = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_INPUT_CURRENT = 8'h89;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_VID = 8'h8b;
  localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8c;
  localparam logic [7:0] CMD_TEMPERATURE = 8'h8d;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_LINEAR = 8'hd4;

  // ===========================================================
  // vendor fault status byte
  localparam int POWER_STAGE_FAULT_BIT = 7;
  localparam int PREBIAS_FAULT_BIT = 6;
  localparam int CURRENT_SHARE_MSB = 5;
  localparam int CURRENT_SHARE_LSB = 3;
  localparam int OUTPUT_RESET_VOLTAGE_BIT = 2;
  localparam int MINIMUM_OUTPUT_VOLTAGE_BIT = 1;
  localparam int PHASE_PULSE_MISSING_BIT = 0;
  localparam logic [7:0] VENDOR_FAULT_STATUS_RESET = 8'h00;

  // ===========================================================
  // communication status byte
  localparam int COMM_MEMORY_FAULT_BIT = 4;
  localparam logic [7:0] COMM_STATUS_RESET = 8'h00;

  // ===========================================================
  // linear word layout
  localparam int LINEAR_EXP_MSB = 15;
  localparam int LINEAR_EXP_LSB = 11;
  localparam int LINEAR_MANT_MSB = 10;
  localparam int LINEAR_EXP_WIDTH = 5;
  localparam int LINEAR_MANT_WIDTH = 11;

  // ===========================================================
  // link framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] IDLE_READ_BYTE = 8'hff;
  localparam logic [6:0] DEFAULT_TARGET_ADDRESS = 7'h5a;  // arbitrary value

endpackage

//--- design/pmft_pin_sync.sv
/*
  Two-stage synchronisers for the serial clock and data pins, with edge,
  start and stop detection on the synchronised levels.
  Assumes the link clock is several times slower than clk.
*/
`timescale 1ns/100ps
`default_nettype none

module pmft_pin_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sclRise,
  output logic sclFall,
  output logic sdaLevel,
  output logic startCond,
  output logic stopCond
);

  logic sclMeta_q, sclSync_q, sclPrev_q;
  logic sdaMeta_q, sdaSync_q, sdaPrev_q;

  // ===========================================================
  // synchronisers and history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= sclPin;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaPin;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  // ===========================================================
  // edges and framing conditions
  assign sclRise = sclSync_q & ~sclPrev_q;
  assign sclFall = ~sclSync_q & sclPrev_q;
  assign sdaLevel = sdaSync_q;
  assign startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  assign stopCond = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

endmodule

`default_nettype wire

//--- design/pmft_regs.sv
/*
  Read-only fault status and telemetry registers behind a PMBus target.
  Fault events and telemetry come from logic on clk; the serial clock and
  data pins come from the board and are synchronised before use.
*/
`timescale 1ns/100ps
`default_nettype none

module pmft_regs
  import pmft_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDRESS = DEFAULT_TARGET_ADDRESS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic powerStageFault,
  input wire logic prebiasFault,
  input wire logic outputResetVoltageFault,
  input wire logic minimumOutputVoltageFault,
  input wire logic phasePulseMissing,
  input wire logic memoryProgramming,
  input wire logic [4:0] inputVoltageExp,
  input wire logic [10:0] inputVoltageMant,
  input wire logic [4:0] inputCurrentExp,
  input wire logic [10:0] inputCurrentMant,
  input wire logic [15:0] outputVoltageVid,
  input wire logic [4:0] outputVoltageExp,
  input wire logic [10:0] outputVoltageMant,
  input wire logic [4:0] outputCurrentExp,
  input wire logic [10:0] outputCurrentMant,
  input wire logic [4:0] temperatureExp,
  input wire logic [10:0] temperatureMant,
  output logic [7:0] vendorFaultStatus,
  output logic memoryFaultFlag
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_CMD = 9'h004,
    ST_WDATA = 9'h008,
    ST_ACK = 9'h010,
    ST_RDATA = 9'h020,
    ST_RACK = 9'h040,
    ST_WAIT = 9'h080,
    ST_SPARE = 9'h100
  } pmft_state_type;

  // ===========================================================
  // linear word packing
  function automatic logic [15:0] packLinear(input logic [4:0] exponent,
                                             input logic [10:0] mantissa);
    logic [15:0] word;
    word = 16'h0000;
    word[LINEAR_EXP_MSB:LINEAR_EXP_LSB] = exponent;  // R9
    word[LINEAR_MANT_MSB:0] = mantissa;  // R9
    return word;
  endfunction

  logic sclRise, sclFall, sdaLevel, startCond, stopCond;

  pmft_pin_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .sdaLevel(sdaLevel),
    .startCond(startCond),
    .stopCond(stopCond)
  );

  pmft_state_type state_q, next_q;
  logic [3:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic [7:0] txShift_q;
  logic [7:0] txHigh_q;
  logic highSent_q;
  logic [7:0] command_q;
  logic sendByteOnly_q;
  logic masterAck_q;
  logic sdaOeN_q;
  logic sdaOut_q;
  logic clearPulse_q;
  logic memWriteEvent_q;
  logic [7:0] faultFlags_q;
  logic memFault_q;

  // ===========================================================
  // command decode
  wire isVendorStatus;
  wire isCommStatus;
  wire isInputVoltage;
  wire isInputCurrent;
  wire isOutputVoltageVid;
  wire isOutputCurrent;
  wire isTemperature;
  wire isOutputVoltageLinear;
  wire isClearFaults;

  assign isVendorStatus = (command_q == CMD_VENDOR_FAULT_STATUS);
  assign isCommStatus = (command_q == CMD_COMM_STATUS);
  assign isInputVoltage = (command_q == CMD_INPUT_VOLTAGE);
  assign isInputCurrent = (command_q == CMD_INPUT_CURRENT);
  assign isOutputVoltageVid = (command_q == CMD_OUTPUT_VOLTAGE_VID);
  assign isOutputCurrent = (command_q == CMD_OUTPUT_CURRENT);
  assign isTemperature = (command_q == CMD_TEMPERATURE);
  assign isOutputVoltageLinear = (command_q == CMD_OUTPUT_VOLTAGE_LINEAR);
  assign isClearFaults = (command_q == CMD_CLEAR_FAULTS);

  // ===========================================================
  // register read decode
  wire [7:0] commStatusByte;
  wire [15:0] readWord;
  wire [7:0] faultEvents;
  wire byteReceived;
  wire addressMatch;
  wire readRequest;
  wire commandDone;
  wire [7:0] nextTxByte;

  assign commStatusByte = COMM_STATUS_RESET | ({7'h00, memFault_q} << COMM_MEMORY_FAULT_BIT);
  assign readWord =
    isVendorStatus ? {IDLE_READ_BYTE, faultFlags_q} :  // R1
    isCommStatus ? {IDLE_READ_BYTE, commStatusByte} :  // R16
    isInputVoltage ? packLinear(inputVoltageExp, inputVoltageMant) :  // R8
    isInputCurrent ? packLinear(inputCurrentExp, inputCurrentMant) :  // R10
    isOutputVoltageVid ? outputVoltageVid :  // R11
    isOutputCurrent ? packLinear(outputCurrentExp, outputCurrentMant) :  // R13
    isTemperature ? packLinear(temperatureExp, temperatureMant) :  // R14
    isOutputVoltageLinear ?
      packLinear(outputVoltageExp, outputVoltageMant) :  // R12
    {IDLE_READ_BYTE, IDLE_READ_BYTE};

  // ===========================================================
  // fault event vector
  assign faultEvents[POWER_STAGE_FAULT_BIT] = powerStageFault;  // R2
  assign faultEvents[PREBIAS_FAULT_BIT] = prebiasFault;  // R3
  assign faultEvents[CURRENT_SHARE_MSB:CURRENT_SHARE_LSB] = 3'h0;  // R4
  assign faultEvents[OUTPUT_RESET_VOLTAGE_BIT] = outputResetVoltageFault;  // R5
  assign faultEvents[MINIMUM_OUTPUT_VOLTAGE_BIT] = minimumOutputVoltageFault;  // R6
  assign faultEvents[PHASE_PULSE_MISSING_BIT] = phasePulseMissing;  // R7

  assign byteReceived = sclFall && (bitCnt_q == BITS_PER_BYTE);
  assign addressMatch = (rxShift_q[7:1] == TARGET_ADDRESS);
  assign readRequest = addressMatch && rxShift_q[0];
  assign commandDone = byteReceived && (state_q == ST_CMD);
  assign nextTxByte = highSent_q ? IDLE_READ_BYTE : txHigh_q;  // R18

  // ===========================================================
  // latched flags: a set in the clear cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faultFlags_q <= VENDOR_FAULT_STATUS_RESET;  // R1
      memFault_q <= 1'b0;
    end else begin
      faultFlags_q <= (faultFlags_q & {8{~clearPulse_q}}) | faultEvents;  // R17
      memFault_q <= (memFault_q & ~clearPulse_q) | memWriteEvent_q;  // R16 R17
    end
  end

  // ===========================================================
  // command capture, kept for the following read or stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      command_q <= 8'h00;
    end else if (commandDone) begin
      command_q <= rxShift_q;
    end
  end

  // ===========================================================
  // link receive, transmit and acknowledge sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      rxShift_q <= 8'h00;
      txShift_q <= 8'hff;
      txHigh_q <= 8'hff;
      highSent_q <= 1'b0;
      sendByteOnly_q <= 1'b0;
      masterAck_q <= 1'b0;
      sdaOeN_q <= 1'b1;
      clearPulse_q <= 1'b0;
      memWriteEvent_q <= 1'b0;
    end else begin
      clearPulse_q <= 1'b0;
      memWriteEvent_q <= 1'b0;
      if (stopCond) begin
        state_q <= ST_IDLE;
        sdaOeN_q <= 1'b1;
        sendByteOnly_q <= 1'b0;
        clearPulse_q <= sendByteOnly_q && isClearFaults;  // R17
      end else if (startCond) begin
        state_q <= ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOeN_q <= 1'b1;
      end else begin
        case (state_q)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (sclRise) begin
              rxShift_q <= {rxShift_q[6:0], sdaLevel};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (byteReceived) begin
              bitCnt_q <= 4'h0;
              sdaOeN_q <= 1'b0;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                if (!addressMatch) begin
                  sdaOeN_q <= 1'b1;
                  state_q <= ST_WAIT;
                end else if (readRequest) begin
                  // snapshot the whole word so both bytes belong together
                  txShift_q <= readWord[7:0];  // R18
                  txHigh_q <= readWord[15:8];  // R18
                  highSent_q <= 1'b0;
                  sendByteOnly_q <= 1'b0;
                  next_q <= ST_RDATA;
                end else begin
                  next_q <= ST_CMD;
                end
              end else if (state_q == ST_CMD) begin
                sendByteOnly_q <= 1'b1;
                next_q <= ST_WDATA;
              end else begin
                // data bytes are acknowledged and dropped
                sendByteOnly_q <= 1'b0;  // R15
                memWriteEvent_q <= memoryProgramming;  // R16
                next_q <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              state_q <= next_q;
              if (next_q == ST_RDATA) begin
                sdaOeN_q <= txShift_q[7];
                txShift_q <= {txShift_q[6:0], 1'b1};
                bitCnt_q <= 4'h1;
              end else begin
                sdaOeN_q <= 1'b1;
                bitCnt_q <= 4'h0;
              end
            end
          end
          ST_RDATA: begin
            if (sclFall) begin
              if (bitCnt_q == BITS_PER_BYTE) begin
                sdaOeN_q <= 1'b1;
                state_q <= ST_RACK;
              end else begin
                sdaOeN_q <= txShift_q[7];
                txShift_q <= {txShift_q[6:0], 1'b1};
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              masterAck_q <= ~sdaLevel;
            end else if (sclFall) begin
              if (masterAck_q) begin
                // low byte went first, then the high byte, then idle bytes
                sdaOeN_q <= nextTxByte[7];  // R18
                txShift_q <= {nextTxByte[6:0], 1'b1};
                highSent_q <= 1'b1;
                bitCnt_q <= 4'h1;
                state_q <= ST_RDATA;
              end else begin
                sdaOeN_q <= 1'b1;
                state_q <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            sdaOeN_q <= 1'b1;
          end
          default: begin
            sdaOeN_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ===========================================================
  // output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_q;
  assign sdaOeN = sdaOeN_q;
  assign vendorFaultStatus = faultFlags_q;
  assign memoryFaultFlag = memFault_q;

endmodule

`default_nettype wire

//--- bench/pmft_regs_sva.sv
/*
  Checker for the fault status and telemetry register set.
  Assumes it is bound onto pmft_regs and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module pmft_regs_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic powerStageFault,
  input wire logic prebiasFault,
  input wire logic outputResetVoltageFault,
  input wire logic minimumOutputVoltageFault,
  input wire logic phasePulseMissing,
  input wire logic memoryProgramming,
  input wire logic [7:0] vendorFaultStatus,
  input wire logic memoryFaultFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ===========================================================
  // flag setting and holding
  ps_set_a: assert property (powerStageFault |=> vendorFaultStatus[7])
    else $error("power stage flag not set");
  pb_set_a: assert property (prebiasFault |=> vendorFaultStatus[6])
    else $error("prebias flag not set");
  share_zero_a: assert property (vendorFaultStatus[5:3] == 3'h0)
    else $error("current share field not zero");
  rv_set_a: assert property (outputResetVoltageFault |=> vendorFaultStatus[2])
    else $error("reset voltage flag not set");
  minv_set_a: assert property (minimumOutputVoltageFault |=> vendorFaultStatus[1])
    else $error("minimum voltage flag not set");
  phase_set_a: assert property (phasePulseMissing |=> vendorFaultStatus[0])
    else $error("phase flag not set");
  mem_cause_a: assert property ($rose(memoryFaultFlag) |-> $past(memoryProgramming))
    else $error("memory fault without programming");
  flag_hold_a: assert property ((|($past(vendorFaultStatus) & ~vendorFaultStatus)
    || $fell(memoryFaultFlag)) |-> sclIn)
    else $error("flag dropped outside a stop");
  ps_c: cover property (powerStageFault);
  clr_c: cover property ($fell(vendorFaultStatus[7]));
  mem_c: cover property ($rose(memoryFaultFlag));
endmodule

bind pmft_regs pmft_regs_sva i_pmft_regs_sva (.clk(clk), .arst_n(arst_n), .sclIn(sclIn),
  .powerStageFault(powerStageFault), .prebiasFault(prebiasFault),
  .outputResetVoltageFault(outputResetVoltageFault),
  .minimumOutputVoltageFault(minimumOutputVoltageFault),
  .phasePulseMissing(phasePulseMissing), .memoryProgramming(memoryProgramming),
  .vendorFaultStatus(vendorFaultStatus), .memoryFaultFlag(memoryFaultFlag));

`default_nettype wire

//--- bench/pmft_host.sv
/*
  Bus host model: drives the serial clock, shares the data wire.
  Assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/100ps
`default_nettype none

module pmft_host (
  input wire logic clk,
  input wire logic sdaOeN,
  output logic sclIn,
  output logic sdaIn
);
  logic hostSda;
  // pulled up unless either side pulls low
  assign sdaIn = hostSda & sdaOeN;
  initial begin
    sclIn = 1'b1;
    hostSda = 1'b1;
  end
  // ===========================================================
  // bit level
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    sclIn <= 1'b0;
    tick(2);
    hostSda <= b;
    tick(2);
    sclIn <= 1'b1;
    tick(2);
    #1 r = sdaIn;
    tick(2);
  endtask
  // lvl 1 makes a start, lvl 0 a stop
  task automatic edge2(input logic lvl);
    sclIn <= 1'b0;
    tick(2);
    hostSda <= lvl;
    tick(2);
    sclIn <= 1'b1;
    tick(4);
    hostSda <= !lvl;
    tick(8);
  endtask
  task automatic byte8(input logic [7:0] d, input logic ai, output logic [7:0] q,
                       output logic ao);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ai, ao);
  endtask
  // ===========================================================
  // frame level
  task automatic xfer(input logic [6:0] addr, input logic [7:0] cmd, input logic wr,
                      input logic [7:0] wd, input int nr, output logic [15:0] rd,
                      output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    rd = 16'hffff;
    edge2(1'b1);
    byte8({addr, 1'b0}, 1'b1, q, a0);
    byte8(cmd, 1'b1, q, a1);
    if (wr) byte8(wd, 1'b1, q, a2);
    if (nr > 0) begin
      edge2(1'b1);
      byte8({addr, 1'b1}, 1'b1, q, a2);
      byte8(8'hff, nr == 1, rd[7:0], a2);
      if (nr > 1) byte8(8'hff, 1'b1, rd[15:8], a2);
    end
    edge2(1'b0);
    ack = !a0 && !a1;
  endtask
endmodule

`default_nettype wire

//--- bench/pmft_regs_tb.sv
/*
  Testbench for the fault status and telemetry register set.
  Assumes pmft_host on the link and the checker bound to the design.
*/
`timescale 1ns/100ps
`default_nettype none

module pmft_regs_tb
  import pmft_pkg::*;
;
  localparam logic [6:0] TA = 7'h21;
  localparam logic [7:0] CMDS [6] = '{CMD_INPUT_VOLTAGE, CMD_INPUT_CURRENT,
    CMD_OUTPUT_VOLTAGE_VID, CMD_OUTPUT_CURRENT, CMD_TEMPERATURE, CMD_OUTPUT_VOLTAGE_LINEAR};
  localparam int BITS [5] = '{7, 6, 2, 1, 0};
  logic clk, arst_n, sclIn, sdaIn, sdaOut, sdaOeN, memoryProgramming, memoryFaultFlag, ack;
  logic [7:0] evt, vendorFaultStatus, exp8;
  logic [15:0] rd;
  logic [15:0] tel [6];
  int errors, testsRun;

  pmft_host i_pmft_host (.clk(clk), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));
  pmft_regs #(.TARGET_ADDRESS(TA)) i_pmft_regs (.clk(clk), .arst_n(arst_n),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .powerStageFault(evt[7]), .prebiasFault(evt[6]), .outputResetVoltageFault(evt[2]),
    .minimumOutputVoltageFault(evt[1]), .phasePulseMissing(evt[0]),
    .memoryProgramming(memoryProgramming),
    .inputVoltageExp(tel[0][15:11]), .inputVoltageMant(tel[0][10:0]),
    .inputCurrentExp(tel[1][15:11]), .inputCurrentMant(tel[1][10:0]),
    .outputVoltageVid(tel[2]),
    .outputVoltageExp(tel[5][15:11]), .outputVoltageMant(tel[5][10:0]),
    .outputCurrentExp(tel[3][15:11]), .outputCurrentMant(tel[3][10:0]),
    .temperatureExp(tel[4][15:11]), .temperatureMant(tel[4][10:0]),
    .vendorFaultStatus(vendorFaultStatus), .memoryFaultFlag(memoryFaultFlag));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ===========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] cmd, input int nr, input logic [15:0] exp);
    i_pmft_host.xfer(TA, cmd, 1'b0, 8'h00, nr, rd, ack);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic w, input logic [7:0] d);
    i_pmft_host.xfer(TA, cmd, w, d, 0, rd, ack);
    chk(16'(ack), 16'h0001);
  endtask
  task automatic pulse(input int b);
    evt <= 8'h01 << b;
    @(posedge clk);
    evt <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic finishTest;
    $display("comparisons %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ===========================================================
  // sequence
  initial begin
    arst_n = 1'b0;
    evt = 8'h00;
    memoryProgramming = 1'b0;
    tel = '{16'hd3a5, 16'h0801, 16'h0123, 16'hf7ff, 16'h8400, 16'h2a5c};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(vendorFaultStatus), 16'h0000);
    chk(16'({sdaOut, sdaOeN}), 16'h0001);
    rdc(CMD_VENDOR_FAULT_STATUS, 1, 16'hff00);
    done("reset");
    for (int i = 0; i < 6; i++) rdc(CMDS[i], 2, tel[i]);
    done("telemetry");
    exp8 = 8'h00;
    foreach (BITS[i]) begin
      pulse(BITS[i]);
      exp8[BITS[i]] = 1'b1;
      chk(16'(vendorFaultStatus), 16'(exp8));
    end
    rdc(CMD_VENDOR_FAULT_STATUS, 1, {8'hff, exp8});
    done("faults");
    wr(CMD_VENDOR_FAULT_STATUS, 1'b1, 8'h00);
    rdc(CMD_VENDOR_FAULT_STATUS, 1, 16'hffc7);
    wr(CMD_INPUT_VOLTAGE, 1'b1, 8'h00);
    rdc(CMD_INPUT_VOLTAGE, 2, tel[0]);
    chk(16'(memoryFaultFlag), 16'h0000);
    done("writes");
    memoryProgramming <= 1'b1;
    wr(CMD_INPUT_CURRENT, 1'b1, 8'h5a);
    memoryProgramming <= 1'b0;
    chk(16'(memoryFaultFlag), 16'h0001);
    rdc(CMD_COMM_STATUS, 1, 16'hff10);
    done("memory");
    wr(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    chk(16'(vendorFaultStatus), 16'h0000);
    chk(16'(memoryFaultFlag), 16'h0000);
    rdc(CMD_VENDOR_FAULT_STATUS, 1, 16'hff00);
    done("clear");
    finishTest();
  end

  initial begin
    #1ms;
    errors++;
    finishTest();
  end
endmodule

`default_nettype wire
